/* rtl/ompl_decode.sv */
// Combinational decoder for one instruction word
module ompl_decode (
    // Word in
    input wire logic [ompl_pkg::WORD_W-1:0] word,
    // Decoded fields
    output ompl_pkg::ompl_op_t op,
    output logic dest_file,
    output logic use_bank,
    output logic [7:0] file_addr,
    output logic [1:0] ptr_sel,
    output logic [3:0] lit_high,
    output logic [7:0] lit_low,
    output logic is_second
);
    import ompl_pkg::*;

    // Field extraction; fields are meaningless for a non-matching op
    assign dest_file = word[9];
    assign use_bank = word[8];
    assign file_addr = word[7:0];
    assign ptr_sel = word[5:4];
    assign lit_high = word[3:0];
    assign lit_low = word[7:0];
    assign is_second = (word[15:8] == OP_SECOND_PFX);

    // Operation class from the opcode prefix
    always_comb begin
        if (word[15:10] == OP_OR_PFX) begin
            op = OPC_OR;
        end else if (word[15:10] == OP_MOVE_PFX) begin
            op = OPC_MOVE;
        end else if (word[15:6] == OP_LDPTR_PFX) begin
            op = OPC_LDPTR;
        end else begin
            op = OPC_NONE;
        end
    end

endmodule

/* rtl/ompl_exec.sv */
// Execute unit for OR-with-file, move-file and two-word pointer load
//
// Added by the designer: the strobed register port and the address map.
module ompl_exec #(
    parameter int NUM_PTR = ompl_pkg::PTR_COUNT
) (
    // Clock, reset, enable
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire logic CLK_EN,
    // Instruction stream, sampled in the decode phase
    input wire logic [ompl_pkg::WORD_W-1:0] INSTR_WORD,
    input wire logic INSTR_VALID,
    output logic [1:0] Q_PHASE,
    // Core state
    input wire logic [ompl_pkg::DATA_W-1:0] W_IN,
    input wire logic [ompl_pkg::BANK_W-1:0] BANK_SEL_IN,
    output logic W_WR,
    output logic [ompl_pkg::DATA_W-1:0] W_DATA,
    output logic FLAG_WR,
    output logic FLAG_N,
    output logic FLAG_Z,
    // Data memory
    output logic MEM_RD,
    output logic MEM_WR,
    output logic [ompl_pkg::ADDR_W-1:0] MEM_ADDR,
    output logic [ompl_pkg::DATA_W-1:0] MEM_WDATA,
    input wire logic [ompl_pkg::DATA_W-1:0] MEM_RDATA,
    // Indirect pointers
    output logic [NUM_PTR-1:0][ompl_pkg::ADDR_W-1:0] INDIRECT_POINTER,
    // Register port
    input wire logic [ompl_pkg::REG_AW-1:0] REG_ADDR,
    input wire logic [ompl_pkg::REG_DW-1:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [ompl_pkg::REG_DW-1:0] REG_RDATA
);
    import ompl_pkg::*;

    // Operand address: access bank when a=0, bank select register when a=1
    function automatic logic [ADDR_W-1:0] form_addr(input logic banked, input logic [7:0] f,
                                                    input logic [BANK_W-1:0] bank);
        logic [BANK_W-1:0] hi;
        hi = bank;
        if (!banked) begin
            hi = (f < ACCESS_SPLIT) ? ACCESS_LO_BANK : ACCESS_HI_BANK;
        end
        form_addr = {hi, f};
    endfunction

    // Whole-word value of a pointer read
    function automatic logic [REG_DW-1:0] widen12(input logic [ADDR_W-1:0] v);
        widen12 = {{(REG_DW - ADDR_W){1'b0}}, v};
    endfunction

    logic [1:0] q_ff;
    logic [WORD_W-1:0] ir_ff;
    logic ir_vld_ff;
    ompl_state_t state_ff;
    logic [1:0] psel_ff;
    logic mem_rd_ff;
    logic mem_wr_ff;
    logic w_wr_ff;
    logic flag_wr_ff;
    logic flag_n_ff;
    logic flag_z_ff;
    logic [ADDR_W-1:0] mem_addr_ff;
    logic [DATA_W-1:0] res_ff;
    logic [REG_DW-1:0] ctrl_ff;
    logic bad_sel_ff;
    logic bad_sec_ff;
    logic [REG_DW-1:0] rdata_ff;
    logic [ADDR_W-1:0] ptr_ff [NUM_PTR];
    ompl_op_t last_op_ff;

    ompl_op_t op;
    logic dest_file;
    logic use_bank;
    logic [7:0] file_addr;
    logic [1:0] ptr_sel;
    logic [3:0] lit_high;
    logic [7:0] lit_low;
    logic is_second;
    logic byte_op;
    logic ptr_hi_we;
    logic ptr_lo_we;
    logic sel_ok;
    logic [DATA_W-1:0] nxt_res;

    ompl_decode u_decode (
        .word(ir_ff),
        .op(op),
        .dest_file(dest_file),
        .use_bank(use_bank),
        .file_addr(file_addr),
        .ptr_sel(ptr_sel),
        .lit_high(lit_high),
        .lit_low(lit_low),
        .is_second(is_second)
    );

    // Qualified decode terms
    assign byte_op = ir_vld_ff && (state_ff == ST_WORD1) && (op == OPC_OR || op == OPC_MOVE);
    assign sel_ok = ({30'h0, ptr_sel} < NUM_PTR);
    assign ptr_hi_we = (q_ff == PH_WRITE) && ir_vld_ff && (state_ff == ST_WORD1)
                       && (op == OPC_LDPTR) && sel_ok;
    assign ptr_lo_we = (q_ff == PH_WRITE) && ir_vld_ff && (state_ff == ST_WORD2) && is_second;

    // Result: OR for the OR op, plain copy for move
    always_comb begin
        nxt_res = MEM_RDATA;
        if (op == OPC_OR) begin
            nxt_res = W_IN | MEM_RDATA;
        end
    end

    // Phase counter; CLK_EN low freezes the whole cycle
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            q_ff <= PH_DECODE;
        end else if (CLK_EN) begin
            q_ff <= q_ff + 2'h1;
        end
    end

    // Instruction capture in the decode phase
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            ir_ff <= 16'h0000;
            ir_vld_ff <= 1'b0;
        end else if (CLK_EN && q_ff == PH_DECODE) begin
            ir_ff <= INSTR_WORD;
            ir_vld_ff <= INSTR_VALID && ctrl_ff[CTRL_EN_BIT];
        end
    end

    // Two-word sequencing; a missing second word simply keeps us waiting
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            state_ff <= ST_WORD1;
            psel_ff <= 2'h0;
        end else if (CLK_EN && q_ff == PH_WRITE && ir_vld_ff) begin
            case (state_ff)
                ST_WORD1: begin
                    if (op == OPC_LDPTR) begin
                        state_ff <= ST_WORD2;
                        psel_ff <= ptr_sel;
                    end
                end
                ST_WORD2: begin
                    state_ff <= ST_WORD1;
                end
                default: begin
                    state_ff <= ST_WORD1;
                end
            endcase
        end
    end

    // Operand read: strobe stands during the process phase only
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            mem_rd_ff <= 1'b0;
            mem_addr_ff <= 12'h000;
        end else if (CLK_EN) begin
            mem_rd_ff <= (q_ff == PH_READ) && byte_op;
            if (q_ff == PH_READ && byte_op) begin
                mem_addr_ff <= form_addr(use_bank, file_addr, BANK_SEL_IN);
            end
        end
    end

    // Result routing at the end of the cycle, one-cycle strobes
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            w_wr_ff <= 1'b0;
            mem_wr_ff <= 1'b0;
            res_ff <= 8'h00;
            last_op_ff <= OPC_NONE;
        end else if (CLK_EN) begin
            w_wr_ff <= (q_ff == PH_WRITE) && byte_op && !dest_file;
            mem_wr_ff <= (q_ff == PH_WRITE) && byte_op && dest_file;
            if (q_ff == PH_WRITE && byte_op) begin
                res_ff <= nxt_res;
                last_op_ff <= op;
            end
        end
    end

    // Flags follow the byte result; pointer loads leave them alone
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            flag_wr_ff <= 1'b0;
            flag_n_ff <= 1'b0;
            flag_z_ff <= 1'b0;
        end else if (CLK_EN) begin
            flag_wr_ff <= (q_ff == PH_WRITE) && byte_op;
            if (q_ff == PH_WRITE && byte_op) begin
                flag_n_ff <= nxt_res[DATA_W-1];
                flag_z_ff <= (nxt_res == 8'h00);
            end
        end
    end

    // One pointer per select code below NUM_PTR; high nibble first, low byte one instruction cycle later
    for (genvar i = 0; i < NUM_PTR; i++) begin : g_ptr
        always_ff @(posedge CORE_CLK) begin
            if (!RST_N) begin
                ptr_ff[i] <= 12'h000;
            end else if (CLK_EN) begin
                if (ptr_hi_we && ptr_sel == 2'(i)) begin
                    ptr_ff[i][ADDR_W-1:8] <= lit_high;
                end
                if (ptr_lo_we && psel_ff == 2'(i)) begin
                    ptr_ff[i][7:0] <= lit_low;
                end
            end
        end
        assign INDIRECT_POINTER[i] = ptr_ff[i];
    end

    // Sticky errors: bad select code, second word without its prefix.
    // Setting wins over a software clear in the same cycle.
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            bad_sel_ff <= 1'b0;
            bad_sec_ff <= 1'b0;
        end else if (CLK_EN) begin
            if ((q_ff == PH_WRITE) && ir_vld_ff && state_ff == ST_WORD1 && op == OPC_LDPTR && !sel_ok) begin
                bad_sel_ff <= 1'b1;
            end else if (REG_WR && REG_ADDR == REG_STATUS && REG_WDATA[ST_BADSEL_BIT]) begin
                bad_sel_ff <= 1'b0;
            end
            if ((q_ff == PH_WRITE) && ir_vld_ff && state_ff == ST_WORD2 && !is_second) begin
                bad_sec_ff <= 1'b1;
            end else if (REG_WR && REG_ADDR == REG_STATUS && REG_WDATA[ST_BADSEC_BIT]) begin
                bad_sec_ff <= 1'b0;
            end
        end
    end

    // Control register write
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            ctrl_ff <= CTRL_RESET;
        end else if (CLK_EN && REG_WR && REG_ADDR == REG_CTRL) begin
            ctrl_ff <= REG_WDATA & CTRL_RESET;
        end
    end

    // Register read, data in the following cycle only; unmapped reads zero
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            rdata_ff <= 16'h0000;
        end else if (CLK_EN) begin
            rdata_ff <= 16'h0000;
            if (REG_RD) begin
                if (REG_ADDR == REG_CTRL) begin
                    rdata_ff <= ctrl_ff;
                end else if (REG_ADDR == REG_STATUS) begin
                    rdata_ff <= {11'h000, bad_sec_ff, bad_sel_ff, state_ff == ST_WORD2, flag_z_ff, flag_n_ff};
                end else begin
                    for (int k = 0; k < NUM_PTR; k++) begin
                        if (REG_ADDR == REG_PTR0 + 4'(k)) begin
                            rdata_ff <= widen12(ptr_ff[k]);
                        end
                    end
                end
            end
        end
    end

    // Outputs straight from flops
    assign Q_PHASE = q_ff;
    assign W_WR = w_wr_ff;
    assign W_DATA = res_ff;
    assign MEM_WDATA = res_ff;
    assign MEM_WR = mem_wr_ff;
    assign MEM_RD = mem_rd_ff;
    assign MEM_ADDR = mem_addr_ff;
    assign FLAG_WR = flag_wr_ff;
    assign FLAG_N = flag_n_ff;
    assign FLAG_Z = flag_z_ff;
    assign REG_RDATA = rdata_ff;

    // OR result is W with the read byte
    or_result_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (CLK_EN && q_ff == PH_WRITE && byte_op && op == OPC_OR)
        |=> (res_ff == ($past(W_IN) | $past(MEM_RDATA))))
        else $error("OR result mismatch");

    // Working register destination never touches the file
    dest_w_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        W_WR |-> (!MEM_WR && !$past(dest_file)))
        else $error("W destination also wrote file");

    // File write lands two cycles after its read, same address
    dest_file_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (MEM_WR && CLK_EN && $past(CLK_EN) && $past(CLK_EN, 2))
        |-> ($past(MEM_RD, 2) && MEM_ADDR == $past(MEM_ADDR, 2)))
        else $error("file write without matching read");

    // Access bank ignores bank select
    access_bank_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (MEM_RD && !use_bank)
        |-> (MEM_ADDR[ADDR_W-1:8] == ((file_addr < ACCESS_SPLIT) ? ACCESS_LO_BANK : ACCESS_HI_BANK)))
        else $error("access bank address wrong");

    // Banked address uses bank select and the full file field
    banked_addr_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        ($rose(MEM_RD) && use_bank) |-> (MEM_ADDR == {$past(BANK_SEL_IN), file_addr}))
        else $error("banked address wrong");

    // Move hands the byte over unaltered
    move_copy_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (CLK_EN && q_ff == PH_WRITE && byte_op && op == OPC_MOVE) |=> (res_ff == $past(MEM_RDATA)))
        else $error("move altered data");

    // High nibble written from the first word
    ptr_high_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (CLK_EN && ptr_hi_we) |=> (ptr_ff[$past(ptr_sel)][ADDR_W-1:8] == $past(lit_high)))
        else $error("pointer high nibble not loaded");

    // Second word pending for a whole instruction cycle
    two_word_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        $rose(state_ff == ST_WORD2) |-> (state_ff == ST_WORD2) [*4])
        else $error("pointer load did not span two cycles");

    // Flags match the result, never from a pointer load
    flags_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        FLAG_WR |-> (FLAG_Z == (res_ff == 8'h00) && FLAG_N == res_ff[DATA_W-1] && last_op_ff != OPC_LDPTR))
        else $error("flags do not match result");

    // Result strobes last one cycle
    one_cycle_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        ((W_WR || MEM_WR) && CLK_EN) |=> !(W_WR || MEM_WR))
        else $error("result strobe longer than a cycle");

    // Pointer loads leave the flags alone
    ld_flags_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (CLK_EN && (ptr_hi_we || ptr_lo_we)) |=> (!FLAG_WR && $stable(FLAG_N) && $stable(FLAG_Z)))
        else $error("pointer load touched the flags");

    // Low byte comes from the second word, into the pointer chosen by the first
    ptr_low_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (CLK_EN && ptr_lo_we && (32'(psel_ff) < NUM_PTR)) |=> (ptr_ff[$past(psel_ff)][7:0] == $past(lit_low)))
        else $error("pointer low byte not loaded");

endmodule

/* rtl/ompl_pkg.sv */
// Package: constants and types for the OR / move / pointer-load execute block
// Functional notes
// - OR opcode 000100da: W OR file byte
// - d=0 sends result to working register
// - d=1 writes result back to file
// - a=0 uses fixed access bank, ignores bank
// - a=1 forms address from bank select register
// - 8-bit file field spans whole bank
// - Move opcode 010100da copies byte unaltered
// - Pointer load writes 12-bit literal, high nibble
// - 2-bit select picks one of three pointers
// - Two words: 1110111000ffkkkk then 11110000kkkkkkkk
package ompl_pkg;

    // Widths
    localparam int DATA_W = 8;
    localparam int ADDR_W = 12;
    localparam int WORD_W = 16;
    localparam int BANK_W = 4;
    localparam int PTR_COUNT = 3;
    localparam int REG_AW = 4;
    localparam int REG_DW = 16;

    // Opcode prefixes, compared against the top bits of a word
    localparam logic [5:0] OP_OR_PFX = 6'h04;
    localparam logic [5:0] OP_MOVE_PFX = 6'h14;
    localparam logic [9:0] OP_LDPTR_PFX = 10'h3b8;
    localparam logic [7:0] OP_SECOND_PFX = 8'hf0;

    // Fixed access bank: low half from bank 0, upper half from the top bank
    localparam logic [7:0] ACCESS_SPLIT = 8'h80;
    localparam logic [BANK_W-1:0] ACCESS_LO_BANK = 4'h0;
    localparam logic [BANK_W-1:0] ACCESS_HI_BANK = 4'hf;

    // Phases of the four-phase instruction cycle
    localparam logic [1:0] PH_DECODE = 2'h0;
    localparam logic [1:0] PH_READ = 2'h1;
    localparam logic [1:0] PH_PROC = 2'h2;
    localparam logic [1:0] PH_WRITE = 2'h3;

    // Register offsets (pointer i sits at REG_PTR0 + i)
    localparam logic [REG_AW-1:0] REG_CTRL = 4'h0;
    localparam logic [REG_AW-1:0] REG_STATUS = 4'h1;
    localparam logic [REG_AW-1:0] REG_PTR0 = 4'h2;

    // Control and status fields
    localparam int CTRL_EN_BIT = 0;
    localparam logic [REG_DW-1:0] CTRL_RESET = 16'h0001;
    localparam int ST_N_BIT = 0;
    localparam int ST_Z_BIT = 1;
    localparam int ST_PEND_BIT = 2;
    localparam int ST_BADSEL_BIT = 3;
    localparam int ST_BADSEC_BIT = 4;

    // Decoded operation class
    typedef enum logic [1:0] {
        OPC_NONE = 2'b00,
        OPC_OR = 2'b01,
        OPC_MOVE = 2'b10,
        OPC_LDPTR = 2'b11
    } ompl_op_t;

    // Word expected next
    typedef enum logic {
        ST_WORD1 = 1'b0,
        ST_WORD2 = 1'b1
    } ompl_state_t;

endpackage

/* verification/testbench.sv */
// Self-checking bench for the OR / move / pointer-load execute block
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import ompl_pkg::*;

    logic CORE_CLK = 1'b0;
    logic RST_N = 1'b0;
    logic CLK_EN = 1'b1;
    logic [WORD_W-1:0] INSTR_WORD = '0;
    logic INSTR_VALID = 1'b0;
    logic [DATA_W-1:0] W_IN = '0;
    logic [BANK_W-1:0] BANK_SEL_IN = '0;
    logic [DATA_W-1:0] MEM_RDATA = '0;
    logic [REG_AW-1:0] REG_ADDR = '0;
    logic [REG_DW-1:0] REG_WDATA = '0;
    logic REG_WR = 1'b0;
    logic REG_RD = 1'b0;
    logic [1:0] Q_PHASE;
    logic W_WR, FLAG_WR, FLAG_N, FLAG_Z, MEM_RD, MEM_WR;
    logic [DATA_W-1:0] W_DATA, MEM_WDATA;
    logic [ADDR_W-1:0] MEM_ADDR;
    logic [PTR_COUNT-1:0][ADDR_W-1:0] INDIRECT_POINTER;
    logic [REG_DW-1:0] REG_RDATA;
    int miscompares = 0;
    int tests_run = 0;
    int cycles = 0;
    int strobes = 0;
    logic [31:0] seed = 32'h43;
    logic [ADDR_W-1:0] ptr_m [PTR_COUNT];
    logic [REG_DW-1:0] rd;

    ompl_exec uut (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .CLK_EN(CLK_EN), .INSTR_WORD(INSTR_WORD),
        .INSTR_VALID(INSTR_VALID), .Q_PHASE(Q_PHASE), .W_IN(W_IN), .BANK_SEL_IN(BANK_SEL_IN), .W_WR(W_WR),
        .W_DATA(W_DATA), .FLAG_WR(FLAG_WR), .FLAG_N(FLAG_N), .FLAG_Z(FLAG_Z), .MEM_RD(MEM_RD), .MEM_WR(MEM_WR),
        .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA), .MEM_RDATA(MEM_RDATA), .INDIRECT_POINTER(INDIRECT_POINTER),
        .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA));

    // 40 MHz core clock
    always #12.5 CORE_CLK = ~CORE_CLK;

    // Hang guard; a full run needs well under a thousand cycles
    always @(posedge CORE_CLK) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            summarize();
        end
    end

    // Count result strobes, so silent operations can be proven silent
    always @(posedge CORE_CLK) begin
        if (RST_N === 1'b1 && (FLAG_WR === 1'b1 || MEM_WR === 1'b1 || W_WR === 1'b1)) strobes++;
    end

    task automatic summarize();
        if (miscompares == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Xorshift generator, fixed start value
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction

    task automatic reg_wr(input logic [REG_AW-1:0] a, input logic [REG_DW-1:0] d);
        @(posedge CORE_CLK);
        REG_ADDR <= a;
        REG_WDATA <= d;
        REG_WR <= 1'b1;
        @(posedge CORE_CLK);
        REG_WR <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic reg_rd(input logic [REG_AW-1:0] a, output logic [REG_DW-1:0] d);
        @(posedge CORE_CLK);
        REG_ADDR <= a;
        REG_RD <= 1'b1;
        @(posedge CORE_CLK);
        REG_RD <= 1'b0;
        @(negedge CORE_CLK);
        d = REG_RDATA;
    endtask

    // Offer a word so that the next edge is a decode-phase take; memory data held steady throughout
    task automatic issue(input logic [15:0] word, input logic [7:0] w, input logic [3:0] bk, input logic [7:0] dat);
        do @(posedge CORE_CLK); while (Q_PHASE !== PH_WRITE);
        INSTR_WORD <= word;
        INSTR_VALID <= 1'b1;
        W_IN <= w;
        BANK_SEL_IN <= bk;
        MEM_RDATA <= dat;
    endtask

    task automatic drop_valid();
        @(posedge CORE_CLK);
        INSTR_VALID <= 1'b0;
        INSTR_WORD <= ~INSTR_WORD;
    endtask

    task automatic chk_ptrs();
        for (int i = 0; i < PTR_COUNT; i++) chk("pointer", 16'(INDIRECT_POINTER[i]), 16'(ptr_m[i]));
    endtask

    // One OR or move, watched for seven cycles, nearly two instruction cycles
    task automatic byte_op(input logic is_or, d, a, input logic [7:0] f, input logic [3:0] bk, input logic [7:0] w,
        input logic [7:0] dat);
        logic [7:0] res;
        logic [11:0] adr;
        int nrd, nmw, nww;
        res = is_or ? (w | dat) : dat;
        adr = a ? {bk, f} : {(f < ACCESS_SPLIT) ? ACCESS_LO_BANK : ACCESS_HI_BANK, f};
        nrd = 0;
        nmw = 0;
        nww = 0;
        issue({is_or ? 6'b000100 : 6'b010100, d, a, f}, w, bk, dat);
        drop_valid();
        repeat (7) begin
            @(negedge CORE_CLK);
            if (MEM_RD === 1'b1) begin
                nrd++;
                chk("mem_addr", 16'(MEM_ADDR), 16'(adr));
                chk("read_phase", 16'(Q_PHASE), 16'(PH_PROC));
            end
            if (MEM_WR === 1'b1 || W_WR === 1'b1) begin
                nmw += (MEM_WR === 1'b1);
                nww += (W_WR === 1'b1);
                chk("write_phase", 16'(Q_PHASE), 16'(PH_DECODE));
                chk("result", 16'(d ? MEM_WDATA : W_DATA), 16'(res));
                chk("flag_wr", 16'(FLAG_WR), 16'h0001);
                chk("flag_n", 16'(FLAG_N), 16'(res[7]));
                chk("flag_z", 16'(FLAG_Z), 16'(res == 8'h00));
            end
        end
        chk("read_count", 16'(nrd), 16'h0001);
        chk("file_write_count", 16'(nmw), 16'(d));
        chk("w_write_count", 16'(nww), 16'(!d));
    endtask

    // Two-word pointer load; pfx is the second word's top byte
    task automatic ld_ptr(input logic [1:0] sel, input logic [11:0] k, input logic [7:0] pfx);
        int s0;
        s0 = strobes;
        issue({8'hee, 2'b00, sel, k[11:8]}, 8'h00, 4'h0, 8'h00);
        drop_valid();
        issue({pfx, k[7:0]}, 8'h00, 4'h0, 8'h00);
        if (sel != 2'h3) ptr_m[sel][11:8] = k[11:8];
        @(negedge CORE_CLK);
        chk_ptrs();
        drop_valid();
        repeat (4) @(posedge CORE_CLK);
        if (sel != 2'h3 && pfx == 8'hf0) ptr_m[sel][7:0] = k[7:0];
        @(negedge CORE_CLK);
        chk_ptrs();
        chk("load_strobes", 16'(strobes - s0), 16'h0000);
    endtask

    initial begin
        for (int i = 0; i < PTR_COUNT; i++) ptr_m[i] = '0;
        repeat (16) @(posedge CORE_CLK);
        RST_N <= 1'b1;
        chk_ptrs();
        reg_rd(REG_CTRL, rd);
        chk("ctrl_reset", rd, CTRL_RESET);
        reg_rd(4'hf, rd);
        chk("unmapped", rd, 16'h0000);
        // Corner cases: access-bank split edges, zero result, bit 7 set
        byte_op(1'b1, 1'b1, 1'b1, 8'h10, 4'h5, 8'h91, 8'h13);
        byte_op(1'b1, 1'b0, 1'b0, 8'h7f, 4'h9, 8'h00, 8'h00);
        byte_op(1'b0, 1'b0, 1'b0, 8'h80, 4'h3, 8'hff, 8'h22);
        byte_op(1'b0, 1'b1, 1'b1, 8'hff, 4'hf, 8'h5a, 8'h00);
        reg_rd(REG_STATUS, rd);
        chk("status_flags", rd, 16'h0002);
        // Random OR and move traffic
        repeat (40) begin
            seed = xs(seed);
            byte_op(seed[0], seed[1], seed[2], seed[15:8], seed[7:4], seed[23:16], seed[31:24]);
        end
        // Each pointer with random literals; full-scale literal on pointer 0 only
        ld_ptr(2'h2, 12'h3ab, 8'hf0);
        ld_ptr(2'h0, 12'hfff, 8'hf0);
        for (int i = 0; i < PTR_COUNT; i++) begin
            seed = xs(seed);
            ld_ptr(2'(i), seed[11:0], 8'hf0);
        end
        for (int i = 0; i < PTR_COUNT; i++) begin
            reg_rd(REG_PTR0 + 4'(i), rd);
            chk("pointer_reg", rd, 16'(ptr_m[i]));
        end
        reg_wr(REG_PTR0, 16'hffff);
        reg_rd(REG_PTR0, rd);
        chk("pointer_read_only", rd, 16'(ptr_m[0]));
        // Select 3 is refused; sticky status bit cleared by writing one
        ld_ptr(2'h3, 12'h123, 8'hf0);
        reg_rd(REG_STATUS, rd);
        chk("bad_select", 16'(rd[ST_BADSEL_BIT]), 16'h0001);
        reg_wr(REG_STATUS, 16'h0008);
        reg_rd(REG_STATUS, rd);
        chk("bad_select_clear", 16'(rd[ST_BADSEL_BIT]), 16'h0000);
        // Second word without its prefix: high part only
        ld_ptr(2'h1, 12'h5a5, 8'h0f);
        reg_rd(REG_STATUS, rd);
        chk("bad_second", 16'(rd[ST_BADSEC_BIT]), 16'h0001);
        ld_ptr(2'h1, 12'ha5a, 8'hf0);
        // Execution disabled: a valid word must do nothing
        reg_wr(REG_CTRL, 16'h0000);
        begin
            int s0;
            s0 = strobes;
            issue({6'b000100, 2'b11, 8'h20}, 8'h0f, 4'h1, 8'hf0);
            drop_valid();
            repeat (8) @(posedge CORE_CLK);
            chk("disabled", 16'(strobes - s0), 16'h0000);
        end
        reg_wr(REG_CTRL, 16'h0001);
        reg_rd(REG_CTRL, rd);
        chk("ctrl_back", rd, 16'h0001);
        // Enable low mid-instruction: phase and strobes freeze, then the move completes
        issue({6'b010100, 2'b11, 8'h44}, 8'h00, 4'h6, 8'h81);
        drop_valid();
        CLK_EN <= 1'b0;
        repeat (5) @(negedge CORE_CLK);
        chk("frozen_phase", 16'(Q_PHASE), 16'(PH_READ));
        chk("frozen_read", 16'(MEM_RD), 16'h0000);
        @(posedge CORE_CLK);
        CLK_EN <= 1'b1;
        repeat (3) @(posedge CORE_CLK);
        @(negedge CORE_CLK);
        chk("frozen_addr", 16'(MEM_ADDR), 16'h0644);
        chk("frozen_result", 16'(MEM_WDATA), 16'h0081);
        chk("frozen_write", 16'(MEM_WR), 16'h0001);
        chk("frozen_flag_n", 16'(FLAG_N), 16'h0001);
        byte_op(1'b1, 1'b0, 1'b1, 8'h33, 4'h2, 8'h80, 8'h01);
        summarize();
    end
endmodule
